// ==== wrlvl_pkg.sv ====
// constants for the leveling feedback and clock change tracker
package wrlvl_pkg;
    localparam int MR1_WL_BIT = 7; // write leveling enable
    localparam int MR1_QOFF_BIT = 12; // output buffers, 1 = off
    localparam int MR1_W = 16;
    localparam int DQ_W = 16;
    localparam int PRIME_LO = 0; // prime line of lower lane
    localparam int PRIME_HI = 8; // prime line of upper lane
    localparam int LANES = 2;
    localparam logic [2:0] RTT_OFF = 3'h0;
    localparam logic [2:0] RTT_60 = 3'h1;
    localparam logic [2:0] RTT_120 = 3'h2;
    localparam logic [2:0] RTT_40 = 3'h3;
    localparam int SYS_CLK_MHZ = 20;
    localparam int TCKSRE_NS = 10; // entry hold before clock may change
    localparam int TCKSRE_CYC = (TCKSRE_NS * SYS_CLK_MHZ + 999) / 1000 < 1 ? 1 :
        (TCKSRE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] TCKSRE_CNT = 4'(TCKSRE_CYC);
endpackage : wrlvl_pkg

// ==== wl_sample_reg.sv ====
// two-stage sampler of the link clock level on a lane strobe edge
`timescale 1ns/1ps
`default_nettype none
module wl_sample_reg
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic strobe_in,
    input wire logic ck_in,
    input wire logic capture_en,
    output logic level_r
);
    logic s1_r;
    logic s2_r;
    logic prev_r;
    logic ck1_r;
    logic ck2_r;
    wire rise = s2_r & ~prev_r;

    // synchronise strobe and clock before any logic looks at them
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            prev_r <= 1'b0;
            ck1_r <= 1'b0;
            ck2_r <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            s1_r <= strobe_in;
            s2_r <= s1_r;
            prev_r <= s2_r;
            ck1_r <= ck_in;
            ck2_r <= ck1_r;
            // RL14: sample on strobe rise
            if (capture_en && rise)
                level_r <= ck2_r;
        end
    end
endmodule : wl_sample_reg
`default_nettype wire

// ==== dram_wrlvl_freq_change.sv ====
// device-side write leveling feedback and clock change gate
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: controller keeps clock period stable
// RL2: frequency change only in refresh/power-down
// RL3: clock ignored after entry hold time
// RL4: frequency-change self refresh meets normal timing
// RL5: power-down change needs CKE low, termination off; the clock gate here checks CKE only, not ODT
// RL6: wait entry hold after CKE falls
// RL7: new clock within speed grade range
// RL8: CKE held low during change
// RL9: stable clock before power-down exit
// RL10: reset DLL after exit and tXP
// RL11: termination off during DLL lock
// RL12: ODT low if nominal termination enabled
// RL13: leveling only as calibration step
// RL14: strobe rise samples clock onto prime line
// RL15: controller steps strobe delay until 0-to-1
// RL16: x8 prime DQ0, others low
// RL17: x16 DQ0 and DQ8 prime, lanes independent
// RL18: MR1 bit7 leveling, bit12 output disable
// RL19: outputs on: strobes input, data output
// RL20: ODT switches only strobe termination
// RL21: outputs off: strobe ignored, data float
// RL22: outputs on: only 40/60/120 termination
// RL23: only NOP or deselect while leveling
// RL24: strobe toggles only after tWLMRD
module dram_wrlvl_freq_change
import wrlvl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [MR1_W-1:0] mr1_value,
    input wire logic mr1_load,
    input wire logic x16_mode,
    input wire logic [2:0] rtt_nom_sel,
    input wire logic ck_level,
    input wire logic [LANES-1:0] dqs_in,
    input wire logic odt_pin,
    input wire logic cke_pin,
    input wire logic self_refresh,
    output logic [DQ_W-1:0] dq_out,
    output logic [DQ_W-1:0] dq_oe,
    output logic [LANES-1:0] dqs_term_on,
    output logic dq_term_on,
    output logic wrlvl_active,
    output logic rtt_illegal,
    output logic clk_dont_care
);
    // clock gate states
    typedef enum logic [1:0] {ST_RUN, ST_ENTER, ST_FREE} clk_state_t;

    logic [MR1_W-1:0] mr1_r;
    // registered pin copies
    logic odt1_r;
    logic odt2_r;
    logic cke1_r;
    logic cke2_r;
    logic sr1_r;
    logic sr2_r;
    logic [3:0] hold_cnt_r;
    logic [3:0] hold_cnt_nxt;
    clk_state_t state_r;
    clk_state_t state_nxt;
    logic [LANES-1:0] level;
    logic [DQ_W-1:0] dq_nxt;
    logic [DQ_W-1:0] oe_nxt;

    // RL18: mode register bit decode
    wire wl_en = mr1_r[MR1_WL_BIT];
    wire outs_on = ~mr1_r[MR1_QOFF_BIT];
    wire lane_ok [LANES];
    wire low_power = ~cke2_r;
    // either low-power state may free the clock
    wire pd_or_sr = low_power || sr2_r;
    // RL22: termination legal with outputs enabled
    wire rtt_ok_on = (rtt_nom_sel == RTT_OFF) || (rtt_nom_sel == RTT_40) ||
        (rtt_nom_sel == RTT_60) || (rtt_nom_sel == RTT_120);

    // mode register word held for decode
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            mr1_r <= 16'h0000;
        else if (mr1_load)
            mr1_r <= mr1_value;
    end

    // synchronise pins; clock enable copies reset high so reset opens no gate
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            odt1_r <= 1'b0;
            odt2_r <= 1'b0;
            cke1_r <= 1'b1;
            cke2_r <= 1'b1;
            sr1_r <= 1'b0;
            sr2_r <= 1'b0;
        end
        else
        begin
            odt1_r <= odt_pin;
            odt2_r <= odt1_r;
            cke1_r <= cke_pin;
            cke2_r <= cke1_r;
            sr1_r <= self_refresh;
            sr2_r <= sr1_r;
        end
    end

    // per-lane samplers; lane 1 used only in x16
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            assign lane_ok[g] = (g == 0) || x16_mode;
            // RL14: strobe rise samples clock
            // RL19: strobe captures only when outputs on
            wl_sample_reg u_smp
            (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .strobe_in(dqs_in[g]),
                .ck_in(ck_level),
                .capture_en(wl_en && outs_on && lane_ok[g]),
                .level_r(level[g])
            );
            // RL20: ODT only switches strobe termination
            assign dqs_term_on[g] = wl_en && odt2_r && lane_ok[g] && (rtt_nom_sel != RTT_OFF);
        end
    endgenerate

    // data line values and enables while leveling
    always_comb
    begin
        dq_nxt = 16'h0000;
        oe_nxt = 16'h0000;
        if (wl_en && outs_on)
        begin
            // RL16: prime DQ0 carries sample, rest low
            dq_nxt[PRIME_LO] = level[0];
            oe_nxt[7:0] = 8'hFF;
            if (x16_mode)
            begin
                // RL17: upper lane prime DQ8
                dq_nxt[PRIME_HI] = level[1];
                oe_nxt[15:8] = 8'hFF;
            end
        end
        // RL21: outputs off leaves all data lines floating
    end

    // registered data lines and enables
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            dq_out <= 16'h0000;
            dq_oe <= 16'h0000;
        end
        else
        begin
            dq_out <= dq_nxt;
            dq_oe <= oe_nxt;
        end
    end

    // fixed and status outputs
    assign dq_term_on = 1'b0; // data never terminated while leveling
    assign wrlvl_active = wl_en;
    assign rtt_illegal = wl_en && outs_on && !rtt_ok_on;

    // RL3: track entry hold before clock is ignored
    always_comb
    begin
        state_nxt = state_r;
        hold_cnt_nxt = hold_cnt_r;
        case (state_r)
            ST_RUN:
            begin
                hold_cnt_nxt = 4'h0;
                if (pd_or_sr)
                    state_nxt = ST_ENTER;
            end
            ST_ENTER:
            begin
                hold_cnt_nxt = hold_cnt_r + 4'h1;
                if (!pd_or_sr)
                    state_nxt = ST_RUN;
                else if (hold_cnt_nxt >= TCKSRE_CNT)
                    state_nxt = ST_FREE;
            end
            ST_FREE:
            begin
                if (!pd_or_sr)
                    state_nxt = ST_RUN;
            end
            default:
                state_nxt = ST_RUN;
        endcase
    end

    // clock gate state and hold counter
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state_r <= ST_RUN;
            hold_cnt_r <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    // clock may change once the entry hold is over
    assign clk_dont_care = (state_r == ST_FREE);
endmodule : dram_wrlvl_freq_change
`default_nettype wire

// ==== dram_wrlvl_freq_change_properties.sv ====
// port checker for leveling feedback and clock gate
`timescale 1ns/1ps
`default_nettype none
module wl_props
import wrlvl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [MR1_W-1:0] mr1_value,
    input wire logic mr1_load,
    input wire logic x16_mode,
    input wire logic ck_level,
    input wire logic [LANES-1:0] dqs_in,
    input wire logic odt_pin,
    input wire logic cke_pin,
    input wire logic [DQ_W-1:0] dq_out,
    input wire logic [DQ_W-1:0] dq_oe,
    input wire logic [LANES-1:0] dqs_term_on,
    input wire logic dq_term_on,
    input wire logic clk_dont_care
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // accepted strobe rise on lane 0
    sequence s_rise;
        $rose(dqs_in[0]) ##0 dq_oe[0];
    endsequence
    // enables two edges after a lone load
    property p_oe;
        mr1_load ##1 !mr1_load |=> dq_oe == ($past(mr1_value[MR1_WL_BIT], 2) &&
            !$past(mr1_value[MR1_QOFF_BIT], 2) ? {{8{x16_mode}}, 8'hff} : 16'h0000);
    endproperty
    chk_prime_fb: assert property (s_rise |-> ##[3:4] dq_out[0] == ck_level)
        else $error("bad feedback");
    chk_rest_low: assert property ((dq_out & 16'hfefe) == 16'h0000)
        else $error("spare line high");
    chk_dq_unterm: assert property (dq_term_on == 1'b0)
        else $error("dq terminated");
    chk_oe_mode: assert property (p_oe)
        else $error("bad enables");
    chk_term_odt: assert property ($rose(dqs_term_on[0]) |-> $past(odt_pin))
        else $error("term without odt");
    chk_gate_open: assert property ($fell(cke_pin) |-> ##[1:6] clk_dont_care)
        else $error("gate not open");
    chk_gate_early: assert property ($rose(clk_dont_care) |-> !$past(cke_pin, 2))
        else $error("gate too early");
    chk_gate_shut: assert property ($rose(cke_pin) |-> ##[1:5] !clk_dont_care)
        else $error("gate not shut");
endmodule : wl_props
bind dram_wrlvl_freq_change wl_props i_props
(
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mr1_value(mr1_value),
    .mr1_load(mr1_load),
    .x16_mode(x16_mode),
    .ck_level(ck_level),
    .dqs_in(dqs_in),
    .odt_pin(odt_pin),
    .cke_pin(cke_pin),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .dqs_term_on(dqs_term_on),
    .dq_term_on(dq_term_on),
    .clk_dont_care(clk_dont_care)
);
`default_nettype wire

// ==== ctrl_model.sv ====
// controller side: sets a clock level then gives one strobe pulse
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic fire,
    input wire logic lane,
    input wire logic ck_val,
    output logic ck_level,
    output logic [1:0] dqs_in
);
    logic [2:0] cnt_r;
    // no commands, clock first, strobe high two then low
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || fire)
            cnt_r <= {2'h0, fire};
        else if (cnt_r != 3'h0)
            cnt_r <= cnt_r + 3'h1;
        if (fire || !rst_b)
            ck_level <= ck_val;
        else if (cnt_r == 3'h7)
            ck_level <= ~ck_level; // level moves on after the hold
        dqs_in <= {2{cnt_r == 3'h1 || cnt_r == 3'h2}} & {lane, !lane};
    end
endmodule : ctrl_model
`default_nettype wire

// ==== dram_wrlvl_freq_change_test.sv ====
// testbench for leveling feedback and clock change gate
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH %0t got %h", $time, a); end end
module dram_wrlvl_freq_change_test;
    import wrlvl_pkg::*;
    logic sys_clk, rst_b, mr1_load, x16_mode, odt_pin, cke_pin, self_refresh;
    logic fire, lane, ck_val, ck_level, dq_term_on, wrlvl_active, rtt_illegal, clk_dont_care;
    logic [15:0] mr1_value, dq_out, dq_oe;
    logic [2:0] rtt_nom_sel;
    logic [1:0] dqs_in, dqs_term_on;
    int num_errors = 0, tests_run = 0, cycles = 0;
    dram_wrlvl_freq_change i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .mr1_value(mr1_value),
        .mr1_load(mr1_load), .x16_mode(x16_mode), .rtt_nom_sel(rtt_nom_sel),
        .ck_level(ck_level), .dqs_in(dqs_in), .odt_pin(odt_pin), .cke_pin(cke_pin),
        .self_refresh(self_refresh), .dq_out(dq_out), .dq_oe(dq_oe),
        .dqs_term_on(dqs_term_on), .dq_term_on(dq_term_on), .wrlvl_active(wrlvl_active),
        .rtt_illegal(rtt_illegal), .clk_dont_care(clk_dont_care));
    ctrl_model i_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .fire(fire), .lane(lane),
        .ck_val(ck_val), .ck_level(ck_level), .dqs_in(dqs_in));
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic wr_mr1(input logic [15:0] v);
        @(posedge sys_clk);
        mr1_value <= v;
        mr1_load <= 1'b1;
        @(posedge sys_clk);
        mr1_load <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : wr_mr1
    task automatic strobe(input logic l, input logic c);
        @(posedge sys_clk);
        {lane, ck_val, fire} <= {l, c, 1'b1};
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
    endtask : strobe
    task automatic pins(input logic cke, input logic sr);
        @(posedge sys_clk);
        {cke_pin, self_refresh} <= {cke, sr};
        repeat (7) @(posedge sys_clk);
        #1;
    endtask : pins
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    // main sequence
    initial
    begin
        {rst_b, mr1_load, x16_mode, odt_pin, self_refresh, fire, lane, ck_val} = 8'h00;
        {cke_pin, rtt_nom_sel, mr1_value} = {1'b1, RTT_40, 16'h0000};
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK(dq_oe, 16'h0000)
        wr_mr1(16'h0080);
        `CHK(dq_oe, 16'h00ff)
        strobe(1'b0, 1'b1);
        `CHK(dq_out, 16'h0001)
        strobe(1'b0, 1'b0);
        `CHK(dq_out, 16'h0000)
        strobe(1'b1, 1'b1);
        `CHK(dq_out, 16'h0000)
        @(posedge sys_clk);
        x16_mode <= 1'b1;
        wr_mr1(16'h0080);
        `CHK(dq_oe, 16'hffff)
        strobe(1'b1, 1'b1);
        `CHK(dq_out, 16'h0100)
        $display("test feedback done");
        @(posedge sys_clk);
        odt_pin <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk);
            rtt_nom_sel <= 3'(i);
            repeat (4) @(posedge sys_clk);
            #1;
            `CHK(rtt_illegal, i > 3)
            `CHK(dqs_term_on, {2{i != 0}})
        end
        @(posedge sys_clk);
        odt_pin <= 1'b0;
        wr_mr1(16'h1080);
        `CHK(dqs_term_on, 2'b00)
        `CHK({rtt_illegal, dq_oe}, 17'h0_0000)
        @(posedge sys_clk);
        odt_pin <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(dqs_term_on, 2'b11)
        @(posedge sys_clk);
        odt_pin <= 1'b0;
        $display("test termination done");
        wr_mr1(16'h0000);
        pins(1'b0, 1'b0);
        `CHK(clk_dont_care, 1'b1)
        pins(1'b1, 1'b0);
        `CHK(clk_dont_care, 1'b0)
        pins(1'b0, 1'b1);
        `CHK(clk_dont_care, 1'b1)
        pins(1'b1, 1'b0);
        `CHK(clk_dont_care, 1'b0)
        wr_mr1(16'h0000);
        `CHK({dqs_term_on, dq_oe}, 18'h0_0000)
        $display("test clock gate done");
        give_verdict();
    end
endmodule : dram_wrlvl_freq_change_test
`default_nettype wire
